/* File: core/lafs_device.sv */
// device end: table pointer, table data port, result queue and status flags
`timescale 1ns/100ps
//
// Contract
// - 7Ah loads count high byte, address low
// - table top ends transfer early
// - count of zero aborts any transfer
// - 7Ch stores word at current address
// - FCh requests table read
// - address advances after each data write
// - table words in queue tagged 110
// - restart flag resets 0, set on restarts
// - power-on or status read clears restart
// - misc engine busy flag, reset 0
// - gain calibration busy flag
// - converter busy on conversion, check, load
// - converter busy drops after scan ends
// - gate calc busy flag, reset 1
// - empty flag high while queue empty
// - queue clear empties, sets empty flag
// - overflow sticky until status read/clear
// - table read never overflows; flag shows full
// - F6h reads status, upper bits zero
// - 80h pops oldest word, tag on top of table and empty words
module lafs_device #(
   parameter int FIFO_DEPTH = 16,
   parameter int TBL_AW     = 8
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // serial link
   lafs_link_if.dev         link,
   // converter results
   input  wire logic        adc_valid,
   input  wire logic [15:0] adc_word,
   // busy sources
   input  wire logic        convert_active,
   input  wire logic        alarm_check,
   input  wire logic        fifo_loading,
   input  wire logic        scan_done,
   input  wire logic        misc_busy_in,
   input  wire logic        gain_cal_in,
   input  wire logic        gate_calc_in,
   // restart and clear events
   input  wire logic        watchdog_reset,
   input  wire logic        full_reset_done,
   input  wire logic        queue_clear,
   // state
   output logic      [15:0] status_flags
);
   localparam int FW = $clog2(FIFO_DEPTH);
   localparam logic [TBL_AW-1:0] TBL_TOP = '1;

   logic [2:0]        pin_s;
   logic              sclk_d;
   logic [4:0]        bit_cnt;
   logic [15:0]       sh_in;
   logic [7:0]        cmd;
   logic [15:0]       sh_out;
   logic              miso_q;
   logic [TBL_AW-1:0] table_addr;
   logic [7:0]        table_word_count;
   logic              tbl_reading;
   logic [15:0]       tbl_mem [2**TBL_AW];
   logic [15:0]       fifo_mem [FIFO_DEPTH];
   logic [FW-1:0]     wr_ptr;
   logic [FW-1:0]     rd_ptr;
   logic [FW:0]       fcount;
   logic              restart;
   logic              engine_misc_busy;
   logic              gain_cal_busy;
   logic              converter_busy;
   logic              gate_calc_busy;
   logic              queue_empty_flag;
   logic              queue_overflow_flag;

   lafs_sync #(.W(3)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({link.sclk, link.cs_n, link.mosi}),
      .q       (pin_s)
   );

   wire sclk_s = pin_s[2];
   wire cs_n_s = pin_s[1];
   wire mosi_s = pin_s[0];
   wire rise   = sclk_s & ~sclk_d & ~cs_n_s;
   wire fall   = ~sclk_s & sclk_d & ~cs_n_s;
   wire [7:0]  cmd_now  = {sh_in[6:0], mosi_s};
   wire [15:0] data_now = {sh_in[14:0], mosi_s};
   wire at_cmd   = rise && (bit_cnt == lafs_pkg::CMD_BITS - 5'h01);
   wire at_end   = rise && (bit_cnt == lafs_pkg::FRAME_BITS - 5'h01);
   wire ev_ptr   = at_end && (cmd == lafs_pkg::CMD_PTR_WR);
   wire ev_wr    = at_end && (cmd == lafs_pkg::CMD_DAT_WR);
   wire ev_rdreq = at_end && (cmd == lafs_pkg::CMD_DAT_RD);
   wire ev_stat  = at_cmd && (cmd_now == lafs_pkg::CMD_STAT_RD);
   wire ev_pop   = at_cmd && (cmd_now == lafs_pkg::CMD_FIFO_RD);

   wire full      = (fcount == (FW+1)'(FIFO_DEPTH));
   wire push_tbl  = tbl_reading && !full;
   wire push_adc  = adc_valid && !tbl_reading && !full;
   wire push      = push_tbl || push_adc;
   wire pop       = ev_pop && (fcount != '0);
   wire tbl_last  = (table_word_count == 8'h01) || (table_addr == TBL_TOP);
   wire [15:0] tbl_word = {lafs_pkg::TAG_TABLE, tbl_mem[table_addr][12:0]};

   wire [15:0] flags = {9'h000, restart, engine_misc_busy, gain_cal_busy,
                        converter_busy, gate_calc_busy, queue_empty_flag,
                        queue_overflow_flag};

   // frame position; a deselect mid-frame discards 7Ah, 7Ch and FCh frames
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sclk_d  <= 1'b0;
         bit_cnt <= '0;
         sh_in   <= '0;
         cmd     <= '0;
      end
      else
      begin
         sclk_d <= sclk_s;
         if (cs_n_s)
            bit_cnt <= '0;
         else if (rise && bit_cnt != lafs_pkg::FRAME_BITS)
            bit_cnt <= bit_cnt + 5'h01;
         if (rise)
            sh_in <= data_now;
         if (at_cmd)
            cmd <= cmd_now;
      end
   end

   // answer word loaded at the command byte, shifted out on falling edges
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sh_out <= '0;
         miso_q <= 1'b0;
      end
      else if (cs_n_s)
      begin
         sh_out <= '0;
         miso_q <= 1'b0;
      end
      else if (ev_stat)
         sh_out <= flags;
      else if (ev_pop)
         // oldest word, or flags when empty
         sh_out <= pop ? fifo_mem[rd_ptr] : {lafs_pkg::TAG_EMPTY, 5'h00, flags[6:0]};
      else if (fall && bit_cnt >= lafs_pkg::CMD_BITS)
      begin
         miso_q <= sh_out[15];
         sh_out <= {sh_out[14:0], 1'b0};
      end
   end

   assign link.miso = miso_q;

   // table pointer, word count and read engine
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         table_addr       <= '0;
         table_word_count <= '0;
         tbl_reading      <= 1'b0;
      end
      else if (ev_ptr)
      begin
         table_word_count <= data_now[15:lafs_pkg::PTR_CNT_LSB];
         table_addr       <= data_now[lafs_pkg::PTR_ADDR_LSB +: TBL_AW];
         tbl_reading      <= 1'b0;
      end
      else if (ev_wr && table_word_count != 8'h00)
      begin
         table_addr       <= table_addr + 1'b1;
         table_word_count <= tbl_last ? 8'h00 : table_word_count - 8'h01;
      end
      else if (ev_rdreq)
         tbl_reading <= (table_word_count != 8'h00);
      else if (push_tbl)
      begin
         table_addr       <= table_addr + 1'b1;
         table_word_count <= tbl_last ? 8'h00 : table_word_count - 8'h01;
         tbl_reading      <= !tbl_last;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (ev_wr && table_word_count != 8'h00)
         tbl_mem[table_addr] <= data_now;
   end

   // queue storage; no reset needed on data
   always_ff @(posedge aclk)
   begin
      if (push)
         fifo_mem[wr_ptr] <= push_tbl ? tbl_word : adc_word;
   end

   // queue pointers; clear outranks a push in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn || queue_clear)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fcount <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == FW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == FW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         fcount <= fcount + (FW+1)'(push) - (FW+1)'(pop);
      end
   end

   // empty and overflow flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         queue_empty_flag    <= lafs_pkg::RST_EMPTY;
         queue_overflow_flag <= 1'b0;
      end
      else
      begin
         if (queue_clear)
            queue_empty_flag <= 1'b1;
         else
            queue_empty_flag <= (fcount + (FW+1)'(push) - (FW+1)'(pop)) == '0;
         if (tbl_reading)
            queue_overflow_flag <= full;
         else if (adc_valid && full)
            queue_overflow_flag <= 1'b1;
         else if (ev_stat || queue_clear)
            queue_overflow_flag <= 1'b0;
      end
   end

   // restart indication
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         restart <= 1'b0;
      else if (watchdog_reset || full_reset_done)
         restart <= 1'b1;
      else if (ev_stat)
         restart <= 1'b0;
   end

   // busy flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         engine_misc_busy <= 1'b0;
         gain_cal_busy    <= 1'b0;
         converter_busy   <= 1'b0;
         gate_calc_busy   <= lafs_pkg::RST_GATE;
      end
      else
      begin
         engine_misc_busy <= misc_busy_in;
         gain_cal_busy    <= gain_cal_in;
         gate_calc_busy   <= gate_calc_in;
         if (convert_active || alarm_check || fifo_loading)
            converter_busy <= 1'b1;
         else if (scan_done)
            converter_busy <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_flags <= {13'h0000, lafs_pkg::RST_GATE, lafs_pkg::RST_EMPTY, 1'b0};
      else
         status_flags <= flags;
   end
endmodule

/* File: core/lafs_pkg.sv */
// shared constants for the table access and status flag link
package lafs_pkg;
   // command bytes
   localparam logic [7:0] CMD_PTR_WR  = 8'h7A;
   localparam logic [7:0] CMD_DAT_WR  = 8'h7C;
   localparam logic [7:0] CMD_DAT_RD  = 8'hFC;
   localparam logic [7:0] CMD_STAT_RD = 8'hF6;
   localparam logic [7:0] CMD_FIFO_RD = 8'h80;
   // frame: command byte then one 16-bit word
   localparam logic [4:0] CMD_BITS    = 5'h08;
   localparam logic [4:0] FRAME_BITS  = 5'h18;
   // pointer register fields
   localparam int PTR_CNT_LSB  = 8;
   localparam int PTR_ADDR_LSB = 0;
   // status flag positions
   localparam int ST_RESTART = 6;
   localparam int ST_MISC    = 5;
   localparam int ST_GAIN    = 4;
   localparam int ST_CONV    = 3;
   localparam int ST_GATE    = 2;
   localparam int ST_EMPTY   = 1;
   localparam int ST_OVF     = 0;
   // status reset values
   localparam logic RST_GATE  = 1'b1;
   localparam logic RST_EMPTY = 1'b1;
   // fifo word tags
   localparam logic [2:0] TAG_TABLE = 3'h6;
   localparam logic [3:0] TAG_EMPTY = 4'hF;
   // serial clock made by the host: 160 ns period from a 5 ns clock
   localparam int CLK_NS      = 5;
   localparam int SCLK_NS     = 160;
   localparam int SCLK_HALF   = SCLK_NS / (2 * CLK_NS);
   // host register offsets
   localparam logic [3:0] REG_CMD   = 4'h0;
   localparam logic [3:0] REG_STAT  = 4'h4;
   localparam logic [3:0] REG_RDATA = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: core/lafs_link_if.sv */
// serial link between the bias controller and its host
`timescale 1ns/100ps
interface lafs_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   modport dev (input sclk, input cs_n, input mosi, output miso);
   modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

/* File: core/lafs_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module lafs_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // pins in, synchronised out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

/* File: core/lafs_host.sv */
// host end: AXI4-Lite command registers driving the serial link
`timescale 1ns/100ps
module lafs_host #(
   parameter int HALF = lafs_pkg::SCLK_HALF
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // serial link
   lafs_link_if.host        link,
   // axi4-lite write
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic      [1:0]  s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [3:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp
);
   typedef enum logic [2:0] {H_IDLE, H_LEAD, H_SHIFT, H_TRAIL, H_GAP} lafs_hstate_e;

   lafs_hstate_e state;
   logic [7:0]   tmr;
   logic [4:0]   bit_n;
   logic [23:0]  tx_sr;
   logic [23:0]  cmd_word;
   logic [15:0]  rx_sr;
   logic         busy;
   logic         aw_got;
   logic         w_got;
   logic [3:0]   aw_addr;
   logic [31:0]  w_data;
   logic [3:0]   w_strb;
   logic         sclk_q;
   logic         cs_n_q;
   logic         mosi_q;
   logic         miso_s;

   lafs_sync #(.W(1)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (link.miso),
      .q       (miso_s)
   );

   wire wr_fire  = aw_got && w_got && !s_axi_bvalid;
   wire wr_cmd   = wr_fire && aw_addr == lafs_pkg::REG_CMD;
   // a command written while a frame runs is dropped; software polls busy
   wire start    = wr_cmd && !busy && (&w_strb);
   wire tmr_done = (tmr == 8'(HALF - 1));

   // write channels taken in either order, response after both
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         aw_addr      <= '0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= lafs_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got  <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == lafs_pkg::REG_CMD) ? lafs_pkg::RESP_OKAY
                                                           : lafs_pkg::RESP_DECERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_got && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= lafs_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= lafs_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
               lafs_pkg::REG_CMD:   s_axi_rdata <= {8'h00, cmd_word};
               lafs_pkg::REG_STAT:  s_axi_rdata <= {31'h00000000, busy};
               lafs_pkg::REG_RDATA: s_axi_rdata <= {16'h0000, rx_sr};
               default:
               begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= lafs_pkg::RESP_DECERR;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // half-period timer of the serial clock divider
   always_ff @(posedge aclk)
   begin
      if (!aresetn || state == H_IDLE || tmr_done)
         tmr <= '0;
      else
         tmr <= tmr + 8'h01;
   end

   // frame sequencer: command byte then 16 data bits, msb first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state    <= H_IDLE;
         busy     <= 1'b0;
         bit_n    <= '0;
         tx_sr    <= '0;
         cmd_word <= '0;
         rx_sr    <= '0;
         sclk_q   <= 1'b0;
         cs_n_q   <= 1'b1;
         mosi_q   <= 1'b0;
      end
      else
      begin
         unique case (state)
            H_IDLE:
               if (start)
               begin
                  state    <= H_LEAD;
                  busy     <= 1'b1;
                  cs_n_q   <= 1'b0;
                  bit_n    <= '0;
                  tx_sr    <= w_data[23:0];
                  cmd_word <= w_data[23:0];
                  mosi_q   <= w_data[23];
               end
            H_LEAD:
               if (tmr_done)
                  state <= H_SHIFT;
            H_SHIFT:
               if (tmr_done && !sclk_q)
               begin
                  sclk_q <= 1'b1;
                  rx_sr  <= {rx_sr[14:0], miso_s};
               end
               else if (tmr_done)
               begin
                  sclk_q <= 1'b0;
                  if (bit_n == lafs_pkg::FRAME_BITS - 5'h01)
                     state <= H_TRAIL;
                  else
                  begin
                     bit_n  <= bit_n + 5'h01;
                     tx_sr  <= {tx_sr[22:0], 1'b0};
                     mosi_q <= tx_sr[22];
                  end
               end
            H_TRAIL:
               if (tmr_done)
               begin
                  state  <= H_GAP;
                  cs_n_q <= 1'b1;
                  mosi_q <= 1'b0;
               end
            H_GAP:
               if (tmr_done)
               begin
                  state <= H_IDLE;
                  busy  <= 1'b0;
               end
         endcase
      end
   end

   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign link.mosi = mosi_q;
endmodule

/* File: test/lafs_assertions.sv */
// link timing and framing checks for the table access link
`timescale 1ns/100ps
module lafs_assertions (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   logic       sclk_q;
   logic [5:0] rises;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // rising clock edges seen inside the current frame
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sclk_q <= 1'b0;
         rises  <= 6'h00;
      end
      else
      begin
         sclk_q <= sclk;
         if (cs_n)
            rises <= 6'h00;
         else if (sclk && !sclk_q)
            rises <= rises + 6'h01;
      end
   end

   // half period is fixed at 8 cycles by the bench
   a_idle_clock: assert property (cs_n |-> !sclk)
      else $error("link clock moved outside a frame");
   // the lead spans the lead half and the first low half
   a_lead_half: assert property ($fell(cs_n) |-> !sclk [*8] ##1 !sclk [*8] ##1 sclk)
      else $error("lead half period wrong");
   a_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("clock high phase wrong");
   a_low_half: assert property ($fell(sclk) |-> !sclk [*8] ##1 (sclk || cs_n))
      else $error("clock low phase wrong");
   a_frame_bits: assert property ($rose(cs_n) |-> rises == 6'h18)
      else $error("frame not 24 bits");
   a_gap_len: assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("gap between frames too short");
   a_mosi_steady: assert property (sclk |-> $stable(mosi))
      else $error("host data moved while clock high");
   a_miso_steady: assert property (sclk |-> $stable(miso))
      else $error("device data moved while clock high");
   a_miso_idle: assert property (cs_n && $past(cs_n, 4) |-> !miso)
      else $error("device data not low when idle");

   c_frame: cover property ($rose(cs_n));
   c_answer: cover property (sclk && miso);
   c_cmd_one: cover property ($fell(cs_n) ##1 mosi);
endmodule

/* File: test/lut_access_and_status_flags_test.sv */
// bench: host and device ends joined over the link, driven over axi4-lite
`timescale 1ns/100ps
module lut_access_and_status_flags_test;
   logic        aclk, aresetn, adc_valid, scan_done, queue_clear;
   logic        convert_active, alarm_check, fifo_loading;
   logic        misc_busy_in, gain_cal_in, gate_calc_in, watchdog_reset, full_reset_done;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] adc_word, status_flags, b;
   logic [15:0] tw[3];
   logic [15:0] aw[17];
   logic [7:0]  base;
   logic [65:0] n;
   logic [65:0] notes[$];
   int          error_cnt, cmp_count;

   lafs_link_if link();
   lafs_host #(.HALF(8)) u_lafs_host (.*);
   lafs_device u_lafs_device (.*);
   lafs_assertions u_lafs_assertions (.aclk(aclk), .aresetn(aresetn), .sclk(link.sclk),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // notes hold {mask, resp, data}; one transfer at a time keeps them in order
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
      notes.push_back({32'h0, r, 32'h0});
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid)
            s_axi_bready <= 1'b0;
      end
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask

   task automatic rd(input logic [3:0] a, input logic [1:0] r, input logic [31:0] e,
                     input logic [31:0] m, output logic [31:0] v);
      notes.push_back({m, r, e});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid)
         begin
            s_axi_rready <= 1'b0;
            v = s_axi_rdata;
         end
      end
      while (s_axi_arvalid || s_axi_rready);
   endtask

   task automatic frame(input logic [7:0] c, input logic [15:0] v);
      logic [31:0] s;
      wr(lafs_pkg::REG_CMD, {8'h00, c, v}, 2'h0);
      s = 32'h1;
      while (s[0])
         rd(lafs_pkg::REG_STAT, 2'h0, 32'h0, 32'hFFFFFFFE, s);
   endtask

   task automatic ans(input logic [15:0] e);
      logic [31:0] s;
      rd(lafs_pkg::REG_RDATA, 2'h0, {16'h0, e}, 32'h0000FFFF, s);
   endtask

   task automatic st(input logic [15:0] e);
      repeat (3) @(posedge aclk);
      chk({16'h0, status_flags}, {16'h0, e});
   endtask

   task automatic fill;
      for (int i = 0; i < 17; i++)
      begin
         aw[i] = 16'($urandom);
         adc_valid <= 1'b1;
         adc_word  <= aw[i];
         @(posedge aclk);
      end
      adc_valid <= 1'b0;
   endtask

   task automatic pulse_clear;
      queue_clear <= 1'b1;
      @(posedge aclk);
      queue_clear <= 1'b0;
   endtask

   always @(posedge aclk)
   begin
      if (s_axi_bvalid && s_axi_bready)
      begin
         n = notes.pop_front();
         chk({30'h0, s_axi_bresp}, {30'h0, n[33:32]});
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
         n = notes.pop_front();
         chk({30'h0, s_axi_rresp}, {30'h0, n[33:32]});
         chk(s_axi_rdata & n[65:34], n[31:0]);
      end
   end

   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   initial
   begin
      repeat (90000) @(posedge aclk);
      error_cnt++;
      wrap_up();
   end

   initial
   begin
      {aresetn, adc_valid, scan_done, queue_clear, convert_active, alarm_check} = '0;
      {fifo_loading, misc_busy_in, gain_cal_in, gate_calc_in, watchdog_reset} = '0;
      {full_reset_done, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, adc_word} = '0;
      s_axi_wstrb = 4'hF;
      void'($urandom(32'hEA498A3F));
      repeat (8) @(posedge aclk);
      chk({16'h0, status_flags}, 32'h6);
      aresetn      <= 1'b1;
      gate_calc_in <= 1'b1;
      repeat (2) @(posedge aclk);
      st(16'h0006);
      rd(4'hC, 2'h3, 32'h0, 32'hFFFFFFFF, d);
      wr(4'hC, 32'h0, 2'h3);
      frame(lafs_pkg::CMD_STAT_RD, 16'h0);
      ans(16'h0006);
      rd(lafs_pkg::REG_CMD, 2'h0, 32'h00F60000, 32'hFFFFFFFF, d);
      // a partial strobe on the command word must not start a frame
      s_axi_wstrb <= 4'h7;
      wr(lafs_pkg::REG_CMD, 32'h00F60000, 2'h0);
      rd(lafs_pkg::REG_STAT, 2'h0, 32'h0, 32'hFFFFFFFF, d);
      s_axi_wstrb <= 4'hF;
      for (int i = 0; i < 2; i++)
      begin
         watchdog_reset  <= (i == 0);
         full_reset_done <= (i == 1);
         @(posedge aclk);
         {watchdog_reset, full_reset_done} <= 2'b00;
         frame(lafs_pkg::CMD_STAT_RD, 16'h0);
         ans(16'h0046);
         frame(lafs_pkg::CMD_STAT_RD, 16'h0);
         ans(16'h0006);
      end
      $display("test reset, decode and restart done");
      for (int i = 0; i < 4; i++)
      begin
         b = 16'($urandom);
         {misc_busy_in, gain_cal_in, gate_calc_in} <= b[2:0];
         st({10'h0, b[2:1], 1'b0, b[0], 2'b10});
      end
      gate_calc_in <= 1'b1;
      {misc_busy_in, gain_cal_in} <= 2'b00;
      for (int i = 0; i < 3; i++)
      begin
         {convert_active, alarm_check, fifo_loading} <= 3'b100 >> i;
         @(posedge aclk);
         {convert_active, alarm_check, fifo_loading} <= 3'b000;
         st(16'h000E);
         scan_done <= 1'b1;
         @(posedge aclk);
         scan_done <= 1'b0;
         st(16'h0006);
      end
      $display("test busy flags done");
      base = 8'($urandom_range(200));
      frame(lafs_pkg::CMD_PTR_WR, {8'h03, base});
      for (int i = 0; i < 3; i++)
      begin
         tw[i] = 16'($urandom);
         frame(lafs_pkg::CMD_DAT_WR, tw[i]);
      end
      // a zero count must block the following data write
      frame(lafs_pkg::CMD_PTR_WR, {8'h02, base + 8'h01});
      frame(lafs_pkg::CMD_PTR_WR, {8'h00, base + 8'h01});
      frame(lafs_pkg::CMD_DAT_WR, ~tw[1]);
      frame(lafs_pkg::CMD_PTR_WR, {8'h03, base});
      frame(lafs_pkg::CMD_DAT_RD, 16'h0);
      st(16'h0004);
      for (int i = 0; i < 3; i++)
      begin
         frame(lafs_pkg::CMD_FIFO_RD, 16'h0);
         ans({3'b110, tw[i][12:0]});
      end
      frame(lafs_pkg::CMD_FIFO_RD, 16'h0);
      ans(16'hF006);
      // the second write would wrap to address zero if the top did not stop it
      tw[0] = 16'($urandom);
      frame(lafs_pkg::CMD_PTR_WR, {8'h02, 8'hFF});
      frame(lafs_pkg::CMD_DAT_WR, tw[0]);
      frame(lafs_pkg::CMD_DAT_WR, ~tw[0]);
      frame(lafs_pkg::CMD_PTR_WR, {8'h02, 8'hFF});
      frame(lafs_pkg::CMD_DAT_RD, 16'h0);
      frame(lafs_pkg::CMD_FIFO_RD, 16'h0);
      ans({3'b110, tw[0][12:0]});
      frame(lafs_pkg::CMD_FIFO_RD, 16'h0);
      ans(16'hF006);
      $display("test table access done");
      fill();
      st(16'h0005);
      for (int i = 0; i < 16; i++)
      begin
         frame(lafs_pkg::CMD_FIFO_RD, 16'h0);
         ans(aw[i]);
      end
      st(16'h0007);
      frame(lafs_pkg::CMD_STAT_RD, 16'h0);
      ans(16'h0007);
      st(16'h0006);
      fill();
      pulse_clear();
      st(16'h0006);
      frame(lafs_pkg::CMD_PTR_WR, {8'h14, 8'h00});
      frame(lafs_pkg::CMD_DAT_RD, 16'h0);
      st(16'h0005);
      frame(lafs_pkg::CMD_PTR_WR, 16'h0000);
      pulse_clear();
      st(16'h0006);
      $display("test queue flags done");
      wrap_up();
   end
endmodule
